// *** hw/pvc_regs.sv ***
// Behaviour
// - control bit13 stops receive error counting
// - bit12 reads auto-negotiation done
// - bit11 selects 1.4 Vpp receive amplitude
// - bit9 enables remote loopback, resets zero
// - bit8 enables DC restoration, resets one
// - bit7 NRZI conversion, reset from strap
// - bit6 4B/5B coding, reset from strap
// - bit5 isolates transmit and MAC side
// - bits4:2 report current operating mode
// - bits1,0 disable MLT-3, scrambler; strapped
// - mode bit11 lowers 10M squelch
// - address bits7:3 strapped; zero isolates
// - mode bit1 accepts preamble-less frames
// - aux bit15 disables jabber detection
// - aux bit14 forces link pass
// - aux bits7,6 squelch level settings
// - aux bits5,4 edge rate, reset one
// - aux bit3 reads auto-negotiation enabled
// - aux bit2 reads speed forced 100
// - aux bits1,0 speed100 and full duplex
// - strapped bits load from pins at reset
`timescale 1ns/1ps
module pvc_regs (
   input wire logic clock,
   input wire logic rst,
   input wire logic mdc,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOe,
   input wire pvc_pkg::pvc_strap_t strap,
   input wire pvc_pkg::pvc_status_t status,
   output pvc_pkg::pvc_ctrl_t ctrl
);
   import pvc_pkg::*;

   // reserved codes never reach software
   function automatic logic [2:0] modeCode(input logic [2:0] raw);
      logic [2:0] m;
      m = raw;
      if (raw == 3'h3 || raw == 3'h4) begin
         m = MODE_NEGOTIATING;
      end
      return m;
   endfunction

   function automatic logic isMapped(input logic [4:0] sel);
      return sel == REG_FAST_DATAPATH_CONTROL || sel == REG_TRANSCEIVER_MODE_CONTROL ||
         sel == REG_AUXILIARY_CONTROL;
   endfunction

   function automatic logic [15:0] readWord(
      input logic [4:0] sel,
      input logic [15:0] fdc,
      input logic [15:0] tmc,
      input logic [15:0] aux,
      input pvc_status_t st
   );
      logic [15:0] w;
      w = 16'h0000;
      case (sel)
         REG_FAST_DATAPATH_CONTROL: begin
            w = fdc;
            w[FDC_AN_DONE] = st.anComplete;
            w[FDC_MODE_LSB +: 3] = modeCode(st.currentOperatingMode);
         end
         REG_TRANSCEIVER_MODE_CONTROL: begin
            w = tmc;
         end
         REG_AUXILIARY_CONTROL: begin
            w = aux;
            w[AUX_AN_EN] = st.anEnable;
            w[AUX_FORCE100] = st.force100;
            w[AUX_SPD100] = st.speed100;
            w[AUX_FDX] = st.fullDuplex;
         end
         default: begin
            w = 16'h0000;
         end
      endcase
      return w;
   endfunction

   logic mdcRise;
   logic mdioBit;
   pvc_strap_t strapMeta_q;
   pvc_strap_t strapSync_q;
   pvc_status_t stat_q;
   pvc_state_t state_q;
   logic [5:0] onesCnt_q;
   logic [3:0] bitCnt_q;
   logic [15:0] shift_q;
   logic [15:0] readShift_q;
   logic opRead_q;
   logic hit_q;
   logic [4:0] regSel_q;
   logic [15:0] fdc_q;
   logic [15:0] tmc_q;
   logic [15:0] aux_q;
   logic addrZero_q;
   logic [11:0] hdrWord;
   logic [15:0] wrData;
   logic wrEn;
   logic opOk;
   logic addrOk;
   logic [15:0] rdWord;

   pvc_mdc_sync u_sync (
      .clock(clock),
      .rst(rst),
      .mdc(mdc),
      .mdioIn(mdioIn),
      .mdcRise(mdcRise),
      .mdioBit(mdioBit)
   );

   // strap pins are asynchronous to the clock
   always_ff @(posedge clock) begin
      strapMeta_q <= strap;
      strapSync_q <= strapMeta_q;
   end

   assign hdrWord = {shift_q[10:0], mdioBit};
   assign wrData = {shift_q[14:0], mdioBit};
   assign wrEn = mdcRise && state_q == ST_WDATA && bitCnt_q == DATA_LAST && hit_q && !opRead_q;
   // a refused frame is still walked to its end so the next preamble is found in step
   assign opOk = hdrWord[11:10] == OP_READ || hdrWord[11:10] == OP_WRITE;
   // match follows the live address field, so software may move the port
   assign addrOk = hdrWord[9:5] == tmc_q[TMC_ADDR_LSB +: 5];
   // one word feeds both the first data bit and the shift register
   assign rdWord = readWord(regSel_q, fdc_q, tmc_q, aux_q, stat_q);

   // frame walker, advances once per management clock rise
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= ST_PRE;
         onesCnt_q <= 6'h00;
         bitCnt_q <= 4'h0;
         shift_q <= 16'h0000;
         opRead_q <= 1'b0;
         hit_q <= 1'b0;
         regSel_q <= 5'h00;
      end else if (mdcRise) begin
         unique case (state_q)
            ST_PRE: begin
               if (mdioBit) begin
                  if (onesCnt_q != PREAMBLE_BITS) begin
                     onesCnt_q <= onesCnt_q + 6'h01;
                  end
               end else begin
                  // short preamble only counts when suppression is allowed
                  if (onesCnt_q == PREAMBLE_BITS || tmc_q[TMC_PRE_SUP]) begin
                     state_q <= ST_START;
                  end
                  onesCnt_q <= 6'h00;
               end
            end
            ST_START: begin
               bitCnt_q <= 4'h0;
               state_q <= mdioBit ? ST_HDR : ST_PRE;
            end
            ST_HDR: begin
               shift_q <= {shift_q[14:0], mdioBit};
               if (bitCnt_q == HDR_LAST) begin
                  bitCnt_q <= 4'h0;
                  opRead_q <= hdrWord[11:10] == OP_READ;
                  regSel_q <= hdrWord[4:0];
                  hit_q <= opOk && addrOk && isMapped(hdrWord[4:0]);
                  state_q <= ST_TA;
               end else begin
                  bitCnt_q <= bitCnt_q + 4'h1;
               end
            end
            ST_TA: begin
               if (bitCnt_q == TA_LAST) begin
                  bitCnt_q <= 4'h0;
                  state_q <= opRead_q ? ST_RDATA : ST_WDATA;
               end else begin
                  bitCnt_q <= bitCnt_q + 4'h1;
               end
            end
            ST_RDATA, ST_WDATA: begin
               shift_q <= {shift_q[14:0], mdioBit};
               if (bitCnt_q == DATA_LAST) begin
                  bitCnt_q <= 4'h0;
                  state_q <= ST_PRE;
               end else begin
                  bitCnt_q <= bitCnt_q + 4'h1;
               end
            end
            default: begin
               state_q <= ST_PRE;
            end
         endcase
      end
   end

   // read data pin: zero during second turnaround bit, then msb first
   always_ff @(posedge clock) begin
      if (rst) begin
         mdioOut <= 1'b0;
         mdioOe <= 1'b0;
         readShift_q <= 16'h0000;
      end else if (mdcRise) begin
         if (state_q == ST_TA && opRead_q && hit_q) begin
            if (bitCnt_q == TA_LAST) begin
               readShift_q <= rdWord;
               mdioOut <= rdWord[15];
            end else begin
               mdioOe <= 1'b1;
               mdioOut <= 1'b0;
            end
         end else if (state_q == ST_RDATA && mdioOe) begin
            readShift_q <= {readShift_q[14:0], 1'b0};
            mdioOut <= readShift_q[14];
            // release on the last data rise so the host may drive the next preamble
            if (bitCnt_q == DATA_LAST) begin
               mdioOe <= 1'b0;
               mdioOut <= 1'b0;
            end
         end
      end
   end

   // datapath control register
   always_ff @(posedge clock) begin
      if (rst) begin
         fdc_q <= FDC_RST_FIXED;
         fdc_q[FDC_NRZI] <= strapSync_q.nrziEn;
         fdc_q[FDC_4B5B] <= strapSync_q.enc4b5bEn;
         fdc_q[FDC_MLT3_DIS] <= strapSync_q.mlt3Disable;
         fdc_q[FDC_SCR_DIS] <= strapSync_q.scramblerDisable;
      end else if (wrEn && regSel_q == REG_FAST_DATAPATH_CONTROL) begin
         fdc_q <= wrData & FDC_WR_MASK;
      end
   end

   // transceiver mode register
   always_ff @(posedge clock) begin
      if (rst) begin
         tmc_q <= TMC_RST_FIXED;
         tmc_q[TMC_ADDR_LSB +: 5] <= strapSync_q.phyAddr;
      end else if (wrEn && regSel_q == REG_TRANSCEIVER_MODE_CONTROL) begin
         tmc_q <= wrData & TMC_WR_MASK;
      end
   end

   // auxiliary control register, status bits merged at read time
   always_ff @(posedge clock) begin
      if (rst) begin
         aux_q <= AUX_RST_FIXED;
      end else if (wrEn && regSel_q == REG_AUXILIARY_CONTROL) begin
         aux_q <= wrData & AUX_WR_MASK;
      end
   end

   // isolation decided by the address seen at reset, not later writes
   always_ff @(posedge clock) begin
      if (rst) begin
         addrZero_q <= strapSync_q.phyAddr == ADDR_ZERO;
      end
   end

   // status snapshot; strapped indications hold their pin value in reset
   always_ff @(posedge clock) begin
      if (rst) begin
         stat_q.anComplete <= 1'b0;
         stat_q.currentOperatingMode <= MODE_NEGOTIATING;
         stat_q.anEnable <= strapSync_q.anEnable;
         stat_q.force100 <= strapSync_q.force100;
         stat_q.speed100 <= 1'b0;
         stat_q.fullDuplex <= strapSync_q.fullDuplex;
      end else begin
         stat_q <= status;
      end
   end

   // control outputs to the datapath
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl <= '0;
      end else begin
         ctrl.rxErrCountDisable <= fdc_q[FDC_RXERR_DIS];
         ctrl.rxAmp14 <= fdc_q[FDC_RX_AMP];
         ctrl.remoteLoopback <= fdc_q[FDC_LOOPBACK];
         ctrl.dcRestoreEn <= fdc_q[FDC_DC_REST];
         ctrl.nrziEn <= fdc_q[FDC_NRZI];
         ctrl.enc4b5bEn <= fdc_q[FDC_4B5B];
         // strapped isolation outlives any later write to bit5
         ctrl.isolate <= fdc_q[FDC_TX_ISO] | addrZero_q;
         ctrl.mlt3Disable <= fdc_q[FDC_MLT3_DIS];
         ctrl.scramblerDisable <= fdc_q[FDC_SCR_DIS];
         ctrl.squelchExtend <= tmc_q[TMC_SQ_EXT];
         ctrl.preambleAccept <= tmc_q[TMC_PRE_SUP];
         ctrl.jabberDisable <= aux_q[AUX_JAB_DIS];
         ctrl.forceLinkPass <= aux_q[AUX_FORCE_LINK];
         ctrl.highSquelchRaise <= aux_q[AUX_HSQ];
         ctrl.lowSquelchLower <= aux_q[AUX_LSQ];
         // edge rate has no function behind it, exported for completeness
         ctrl.edgeRate <= aux_q[AUX_EDGE_LSB +: 2];
      end
   end
endmodule

// *** hw/pvc_pkg.sv ***
package pvc_pkg;

   // management register offsets
   localparam logic [4:0] REG_FAST_DATAPATH_CONTROL = 5'h13;
   localparam logic [4:0] REG_TRANSCEIVER_MODE_CONTROL = 5'h14;
   localparam logic [4:0] REG_AUXILIARY_CONTROL = 5'h18;

   // fast_datapath_control fields
   localparam int FDC_RXERR_DIS = 13;
   localparam int FDC_AN_DONE = 12;
   localparam int FDC_RX_AMP = 11;
   localparam int FDC_LOOPBACK = 9;
   localparam int FDC_DC_REST = 8;
   localparam int FDC_NRZI = 7;
   localparam int FDC_4B5B = 6;
   localparam int FDC_TX_ISO = 5;
   localparam int FDC_MODE_LSB = 2;
   localparam int FDC_MLT3_DIS = 1;
   localparam int FDC_SCR_DIS = 0;
   localparam logic [15:0] FDC_WR_MASK = 16'h2FE3;
   localparam logic [15:0] FDC_RST_FIXED = 16'h0100;

   // transceiver_mode_control fields
   localparam int TMC_SQ_EXT = 11;
   localparam int TMC_ADDR_LSB = 3;
   localparam int TMC_PRE_SUP = 1;
   localparam logic [15:0] TMC_WR_MASK = 16'h08FA;
   localparam logic [15:0] TMC_RST_FIXED = 16'h0002;

   // auxiliary_control fields
   localparam int AUX_JAB_DIS = 15;
   localparam int AUX_FORCE_LINK = 14;
   localparam int AUX_HSQ = 7;
   localparam int AUX_LSQ = 6;
   localparam int AUX_EDGE_LSB = 4;
   localparam int AUX_AN_EN = 3;
   localparam int AUX_FORCE100 = 2;
   localparam int AUX_SPD100 = 1;
   localparam int AUX_FDX = 0;
   localparam logic [15:0] AUX_WR_MASK = 16'hC0F0;
   localparam logic [15:0] AUX_RST_FIXED = 16'h0030;

   // current_operating_mode codes
   localparam logic [2:0] MODE_NEGOTIATING = 3'h0;
   localparam logic [2:0] MODE_10_HALF = 3'h1;
   localparam logic [2:0] MODE_100_HALF = 3'h2;
   localparam logic [2:0] MODE_10_FULL = 3'h5;
   localparam logic [2:0] MODE_100_FULL = 3'h6;
   localparam logic [2:0] MODE_ISOLATED = 3'h7;

   // management frame layout
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [5:0] PREAMBLE_BITS = 6'h20;
   localparam logic [3:0] HDR_LAST = 4'hB;
   localparam logic [3:0] TA_LAST = 4'h1;
   localparam logic [3:0] DATA_LAST = 4'hF;
   localparam logic [4:0] ADDR_ZERO = 5'h00;

   typedef enum logic [5:0] {
      ST_PRE = 6'h01,
      ST_START = 6'h02,
      ST_HDR = 6'h04,
      ST_TA = 6'h08,
      ST_RDATA = 6'h10,
      ST_WDATA = 6'h20
   } pvc_state_t;

   typedef struct packed {
      logic nrziEn;
      logic enc4b5bEn;
      logic mlt3Disable;
      logic scramblerDisable;
      logic [4:0] phyAddr;
      logic anEnable;
      logic force100;
      logic fullDuplex;
   } pvc_strap_t;

   typedef struct packed {
      logic anComplete;
      logic [2:0] currentOperatingMode;
      logic anEnable;
      logic force100;
      logic speed100;
      logic fullDuplex;
   } pvc_status_t;

   typedef struct packed {
      logic rxErrCountDisable;
      logic rxAmp14;
      logic remoteLoopback;
      logic dcRestoreEn;
      logic nrziEn;
      logic enc4b5bEn;
      logic isolate;
      logic mlt3Disable;
      logic scramblerDisable;
      logic squelchExtend;
      logic preambleAccept;
      logic jabberDisable;
      logic forceLinkPass;
      logic highSquelchRaise;
      logic lowSquelchLower;
      logic [1:0] edgeRate;
   } pvc_ctrl_t;

endpackage

// *** hw/pvc_mdc_sync.sv ***
`timescale 1ns/1ps
module pvc_mdc_sync (
   input wire logic clock,
   input wire logic rst,
   input wire logic mdc,
   input wire logic mdioIn,
   output logic mdcRise,
   output logic mdioBit
);
   import pvc_pkg::*;

   logic mdcMeta_q;
   logic mdcSync_q;
   logic mdcPrev_q;
   logic mdioMeta_q;
   logic mdioSync_q;

   // first stages feed only the second stages
   always_ff @(posedge clock) begin
      mdcMeta_q <= mdc;
      mdcSync_q <= mdcMeta_q;
      mdioMeta_q <= mdioIn;
      mdioSync_q <= mdioMeta_q;
   end

   // rise pulse and data bit leave aligned, both registered
   always_ff @(posedge clock) begin
      if (rst) begin
         mdcPrev_q <= 1'b0;
         mdcRise <= 1'b0;
         mdioBit <= 1'b1;
      end else begin
         mdcPrev_q <= mdcSync_q;
         mdcRise <= mdcSync_q & ~mdcPrev_q;
         mdioBit <= mdioSync_q;
      end
   end
endmodule

// *** test/pvc_regs_sva.sv ***
`timescale 1ns/1ps
module pvc_regs_sva (
   input wire logic clock,
   input wire logic rst,
   input wire logic mdc,
   input wire logic mdioIn,
   input wire logic mdioOut,
   input wire logic mdioOe,
   input wire pvc_pkg::pvc_strap_t strap,
   input wire pvc_pkg::pvc_status_t status,
   input wire pvc_pkg::pvc_ctrl_t ctrl
);
   import pvc_pkg::*;
   logic mdcSeen_q;
   logic [3:0] mdcAge_q;
   logic [4:0] oeRises_q;
   logic addrZero_q;
   always_ff @(posedge clock) begin
      mdcSeen_q <= mdc;
   end
   // clocks since the last raw mdc rise, saturating
   always_ff @(posedge clock) begin
      if (rst) begin
         mdcAge_q <= 4'hF;
      end else if (mdc && !mdcSeen_q) begin
         mdcAge_q <= 4'h0;
      end else if (mdcAge_q != 4'hF) begin
         mdcAge_q <= mdcAge_q + 4'h1;
      end
   end
   // mdc rises seen while the device drives
   always_ff @(posedge clock) begin
      if (!mdioOe) begin
         oeRises_q <= 5'h00;
      end else if (mdc && !mdcSeen_q) begin
         oeRises_q <= oeRises_q + 5'h01;
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         addrZero_q <= (strap.phyAddr == ADDR_ZERO);
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_reset_clear: assert property ($fell(rst) |-> !mdioOe && ctrl == '0)
      else $error("outputs not quiet at reset release");
   a_reset_values: assert property ($past(rst, 2) && !$past(rst) |->
      ctrl.dcRestoreEn && ctrl.preambleAccept && ctrl.edgeRate == 2'h3 && !ctrl.jabberDisable
      && !ctrl.forceLinkPass && !ctrl.rxErrCountDisable && !ctrl.remoteLoopback
      && ctrl.nrziEn == strap.nrziEn && ctrl.enc4b5bEn == strap.enc4b5bEn
      && ctrl.mlt3Disable == strap.mlt3Disable && ctrl.scramblerDisable == strap.scramblerDisable)
      else $error("control outputs wrong after reset");
   a_iso_strap: assert property (!$past(rst, 2) && addrZero_q |-> ctrl.isolate)
      else $error("zero strapped address not isolating");
   a_idle_low: assert property (!mdioOe |-> !mdioOut)
      else $error("data high while not driving");
   a_ta_zero: assert property ($rose(mdioOe) |-> !mdioOut)
      else $error("turnaround not driven low");
   a_read_span: assert property ($fell(mdioOe) |-> oeRises_q == 5'h11)
      else $error("read drive window not seventeen mdc periods");
   a_bit_timing: assert property ($changed(mdioOut) || $changed(mdioOe) |->
      mdcAge_q inside {[4'h2:4'h6]})
      else $error("data line moved away from mdc rise");
   a_ctrl_timing: assert property (!$past(rst, 2) && $changed(ctrl) |->
      mdcAge_q inside {[4'h2:4'h7]})
      else $error("control changed without a management write");
   c_read: cover property ($fell(mdioOe));
   c_jabber: cover property ($rose(ctrl.jabberDisable));
   c_iso: cover property (addrZero_q && ctrl.isolate);
endmodule

bind pvc_regs pvc_regs_sva i_sva (.clock(clock), .rst(rst), .mdc(mdc), .mdioIn(mdioIn),
   .mdioOut(mdioOut), .mdioOe(mdioOe), .strap(strap), .status(status), .ctrl(ctrl));

// *** test/pvc_host_model.sv ***
`timescale 1ns/1ps
module pvc_host_model (
   input wire logic clock,
   output logic mdc,
   output logic mdioOut,
   output logic mdioOe,
   input wire logic mdioWire
);
   import pvc_pkg::*;
   // mdc stands low between frames
   initial begin
      mdc = 1'b0;
      mdioOut = 1'b1;
      mdioOe = 1'b0;
   end
   // data changes only while mdc is low, sampled as mdc rises
   task automatic send_bit(input logic b, input logic drive, output logic seen);
      @(negedge clock);
      mdc = 1'b0;
      mdioOut = b;
      mdioOe = drive;
      repeat (4) @(negedge clock);
      mdc = 1'b1;
      seen = mdioWire;
      repeat (3) @(negedge clock);
   endtask
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
         input logic [15:0] wd, input bit pre, output logic [15:0] rd);
      logic [31:0] frm;
      logic v;
      frm = {2'b01, op, pa, ra, 2'b10, wd};
      if (pre) begin
         repeat (32) send_bit(1'b1, 1'b1, v);
      end
      // line released from turnaround on for reads
      for (int i = 31; i >= 0; i--) begin
         send_bit(frm[i], !(op == OP_READ && i < 18), v);
         if (i < 16) begin
            rd[i] = v;
         end
      end
      @(negedge clock);
      mdc = 1'b0;
      mdioOe = 1'b0;
   endtask
endmodule

// *** test/pvc_regs_test.sv ***
`timescale 1ns/1ps
module pvc_regs_test;
   import pvc_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic mdc, hostOut, hostOe, mdioOut, mdioOe, mdioWire;
   pvc_strap_t strap = pvc_strap_t'(12'hA55);
   pvc_status_t status = pvc_status_t'(8'hDB);
   pvc_ctrl_t ctrl;
   int errTotal = 0;
   int nTests = 0;
   logic [4:0] pa = 5'h0A;
   logic [15:0] rd;
   always #20 clock = ~clock;
   // pull-up when nobody drives
   assign mdioWire = mdioOe ? mdioOut : (hostOe ? hostOut : 1'b1);
   pvc_regs i_dut (.clock(clock), .rst(rst), .mdc(mdc), .mdioIn(mdioWire), .mdioOut(mdioOut),
      .mdioOe(mdioOe), .strap(strap), .status(status), .ctrl(ctrl));
   pvc_host_model i_host (.clock(clock), .mdc(mdc), .mdioOut(hostOut), .mdioOe(hostOe),
      .mdioWire(mdioWire));
   function automatic logic [15:0] fdc_exp(input logic [15:0] w);
      logic [2:0] m;
      m = status.currentOperatingMode;
      if (m == 3'h3 || m == 3'h4) begin
         m = MODE_NEGOTIATING;
      end
      return (w & FDC_WR_MASK) | (16'(status.anComplete) << FDC_AN_DONE)
         | (16'(m) << FDC_MODE_LSB);
   endfunction
   function automatic logic [15:0] aux_exp(input logic [15:0] w);
      return (w & AUX_WR_MASK) | {12'h000, status.anEnable, status.force100, status.speed100,
         status.fullDuplex};
   endfunction
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      nTests++;
      if (got !== exp) begin
         errTotal++;
         $display("MISMATCH t=%0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_ctrl(input pvc_ctrl_t exp);
      repeat (8) @(negedge clock);
      nTests++;
      if (ctrl !== exp) begin
         errTotal++;
         $display("MISMATCH t=%0t ctrl %h expected %h", $time, ctrl, exp);
      end
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] d, input bit pre = 1'b1);
      i_host.xfer(OP_WRITE, pa, ra, d, pre, rd);
   endtask
   task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
      i_host.xfer(OP_READ, pa, ra, 16'h0000, 1'b1, rd);
      chk16(rd, exp);
   endtask
   task automatic do_reset(input pvc_strap_t s);
      @(negedge clock);
      strap = s;
      rst = 1'b1;
      repeat (16) @(negedge clock);
      rst = 1'b0;
      pa = s.phyAddr;
      repeat (2) @(negedge clock);
   endtask
   task automatic end_test(input string name);
      $display("test %s finished, mismatches so far %0d", name, errTotal);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // about 20k cycles expected, generous margin
   initial begin
      repeat (90000) @(posedge clock);
      errTotal++;
      report_and_stop();
   end
   initial begin
      do_reset(pvc_strap_t'(12'hA55));
      rd_chk(REG_FAST_DATAPATH_CONTROL, fdc_exp(16'h0182));
      rd_chk(REG_TRANSCEIVER_MODE_CONTROL, 16'h0052);
      rd_chk(REG_AUXILIARY_CONTROL, aux_exp(16'h0030));
      chk_ctrl(pvc_ctrl_t'(17'h0_3243));
      end_test("reset");
      // reserved bits written zero, read-only bits written one
      wr(REG_FAST_DATAPATH_CONTROL, 16'h3BFF);
      wr(REG_AUXILIARY_CONTROL, 16'hC0FF);
      wr(REG_TRANSCEIVER_MODE_CONTROL, 16'h0850);
      // suppression now off: a preamble-less write must be ignored
      wr(REG_FAST_DATAPATH_CONTROL, 16'h0000, 1'b0);
      rd_chk(REG_FAST_DATAPATH_CONTROL, fdc_exp(16'h3BFF));
      rd_chk(REG_TRANSCEIVER_MODE_CONTROL, 16'h0850);
      rd_chk(REG_AUXILIARY_CONTROL, aux_exp(16'hC0FF));
      chk_ctrl(pvc_ctrl_t'(17'h1_FFBF));
      end_test("set");
      wr(REG_TRANSCEIVER_MODE_CONTROL, 16'h0052);
      wr(REG_FAST_DATAPATH_CONTROL, 16'h0000, 1'b0);
      wr(REG_AUXILIARY_CONTROL, 16'h0000, 1'b0);
      rd_chk(REG_FAST_DATAPATH_CONTROL, fdc_exp(16'h0000));
      rd_chk(REG_AUXILIARY_CONTROL, aux_exp(16'h0000));
      chk_ctrl(pvc_ctrl_t'(17'h0_0040));
      end_test("clear");
      pa = 5'h0B;
      wr(REG_AUXILIARY_CONTROL, 16'hC000);
      rd_chk(REG_AUXILIARY_CONTROL, 16'hFFFF);
      pa = 5'h0A;
      // illegal opcode must not write
      i_host.xfer(2'h3, pa, REG_AUXILIARY_CONTROL, 16'hC000, 1'b1, rd);
      rd_chk(REG_AUXILIARY_CONTROL, aux_exp(16'h0000));
      rd_chk(5'h15, 16'hFFFF);
      end_test("refused");
      for (int c = 0; c < 8; c++) begin
         status.currentOperatingMode = 3'(c);
         status.anComplete = c[0];
         status.speed100 = c[1];
         status.fullDuplex = c[2];
         status.anEnable = c[1];
         status.force100 = ~c[0];
         rd_chk(REG_FAST_DATAPATH_CONTROL, fdc_exp(16'h0000));
         rd_chk(REG_AUXILIARY_CONTROL, aux_exp(16'h0000));
      end
      end_test("status");
      do_reset(pvc_strap_t'(12'h005));
      rd_chk(REG_TRANSCEIVER_MODE_CONTROL, 16'h0002);
      chk_ctrl(pvc_ctrl_t'(17'h0_2443));
      end_test("isolate");
      report_and_stop();
   end
endmodule
